// ---- dkrd_pkg.sv ----
// What this block does
// RULE_01 - type A read: option 15-12, zero 11, head 10-08, sector 05-00
// RULE_02 - codes 0000-0101 pick the six basic reads
// RULE_03 - type B: option 15-12, head 11-07, 06 zero, sector 05-00
// RULE_04 - type B adds options 0110, 1000, 1010
// RULE_05 - type B track buffer: 48 sectors, 12 per drive
// RULE_06 - type B read-ahead wraps to next head at sector 0; no read-ahead here, a continued read keeps its head
// RULE_07 - continue-read queues one read, issued when current ends
// RULE_08 - drive finds the sector, then sends 2048 parcels
// RULE_09 - type B sectors 0-11,16-27,32-43,48-59 are slots 0-47
// RULE_10 - read sector ID moves 16 parcels
// RULE_11 - type A ID read without sync: no data, error
// RULE_12 - type A defective-ID sector gives sync timeout
// RULE_13 - type A ID parcel k: nibble k of each channel
// RULE_14 - channel ID nibbles: head, cylinder, sector
// RULE_15 - ID nibbles 6-7: inverted xor parity
// RULE_16 - type B ID fields in parcels 0-2
// RULE_17 - absolute read skips ID compare, 2048 parcels
// RULE_18 - read buffer: 16 parcels, bus-out ignored
// RULE_19 - type A ECC: 48-bit syndrome per channel
// RULE_20 - type A: zero syndrome without ECC error
// RULE_21 - type B syndrome in parcels 0 and 1
// RULE_22 - store parcels, ack 0110 per 16, toggle buffer on done
// RULE_23 - continue flag parcel three bit 15, next sector in parcel two
// RULE_24 - unused and zero bus-out bits driven low
`default_nettype none
package dkrd_pkg;
  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] DKRD_CMD_OFF    = 8'h00;
  localparam logic [7:0] DKRD_PARC2_OFF  = 8'h04;
  localparam logic [7:0] DKRD_PARC3_OFF  = 8'h08;
  localparam logic [7:0] DKRD_STAT_OFF   = 8'h0c;
  localparam logic [7:0] DKRD_LASTBO_OFF = 8'h10;
  localparam logic [7:0] DKRD_BADDR_OFF  = 8'h14;
  localparam logic [7:0] DKRD_BDATA_OFF  = 8'h18;
  localparam int         DKRD_CMD_TYPEB_BIT = 8;
  localparam int         DKRD_CONT_BIT      = 15;
  localparam logic [15:0] DKRD_REG_RST   = 16'h0000;
  // ==========================================================================
  // read option codes
  localparam logic [3:0] DKRD_OPT_DATA   = 4'h0;
  localparam logic [3:0] DKRD_OPT_ID     = 4'h1;
  localparam logic [3:0] DKRD_OPT_ABS    = 4'h2;
  localparam logic [3:0] DKRD_OPT_BUF    = 4'h3;
  localparam logic [3:0] DKRD_OPT_ECC    = 4'h4;
  localparam logic [3:0] DKRD_OPT_VEC    = 4'h5;
  localparam logic [3:0] DKRD_OPT_HDR    = 4'h6;
  localparam logic [3:0] DKRD_OPT_NOCONT = 4'h8;
  localparam logic [3:0] DKRD_OPT_TBUF   = 4'ha;
  localparam logic [3:0] DKRD_FN_DATA_ACK = 4'h6;
  // ==========================================================================
  // transfer lengths and track buffer geometry
  localparam logic [11:0] DKRD_LEN_LONG  = 12'h800;
  localparam logic [11:0] DKRD_LEN_SHORT = 12'h010;
  localparam logic [5:0]  DKRD_TRK_SECTORS   = 6'h30;
  localparam logic [5:0]  DKRD_SECT_PER_DRV  = 6'h0c;
  localparam logic [5:0]  DKRD_DRV_STRIDE    = 6'h10;
  // ==========================================================================
  // bus responses and states
  localparam logic [1:0] DKRD_RESP_OKAY   = 2'b00;
  localparam logic [1:0] DKRD_RESP_SLVERR = 2'b10;
  localparam logic [1:0] DKRD_RESP_DECERR = 2'b11;
  typedef enum logic [0:0] {
    DKRD_IDLE = 1'b0,
    DKRD_XFER = 1'b1
  } dkrd_state_t;
endpackage : dkrd_pkg
`default_nettype wire

// ---- dkrd_if.sv ----
`default_nettype none
// ==========================================================================
// bus slave to register file
interface dkrd_reg_if;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [1:0]  wr_resp;
  logic        rd_stb;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic [1:0]  rd_resp;
  modport slave (output wr_stb, wr_addr, wr_data, wr_strb, rd_stb, rd_addr,
                 input wr_resp, rd_data, rd_resp);
  modport regs  (input wr_stb, wr_addr, wr_data, wr_strb, rd_stb, rd_addr,
                 output wr_resp, rd_data, rd_resp);
endinterface : dkrd_reg_if

// ==========================================================================
// parcel buffer port
interface dkrd_mem_if #(parameter int AW = 13);
  logic          we;
  logic [AW-1:0] waddr;
  logic [15:0]   wdata;
  logic [AW-1:0] raddr;
  logic [15:0]   rdata;
  modport mem  (input we, waddr, wdata, raddr, output rdata);
  modport user (output we, waddr, wdata, raddr, input rdata);
endinterface : dkrd_mem_if
`default_nettype wire

// ---- dkrd_buf_mem.sv ----
`default_nettype none
// two parcel buffers side by side; top address bit picks the buffer
module dkrd_buf_mem
  import dkrd_pkg::*;
#(
  parameter int AW = 13
) (
  input wire logic  clk_i,
  dkrd_mem_if.mem   port
);
  typedef struct packed {
    logic [15:0] rdata;
  } dkrd_mem_st_t;

  logic [15:0]  store [0:(1<<AW)-1];
  dkrd_mem_st_t st;
  dkrd_mem_st_t next_st;

  // ==========================================================================
  // registered read: data one cycle after the address
  always_comb begin
    next_st       = st;
    next_st.rdata = store[port.raddr];
  end

  // array has no reset: ram has no defined power-up value
  always_ff @(posedge clk_i) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
    st <= next_st;
  end

  assign port.rdata = st.rdata;
endmodule : dkrd_buf_mem
`default_nettype wire

// ---- dkrd_axil_slv.sv ----
`default_nettype none
module dkrd_axil_slv
  import dkrd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  dkrd_reg_if.slave        rif
);
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        ar_got;
    logic [7:0]  raddr;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dkrd_axi_st_t;

  dkrd_axi_st_t st;
  dkrd_axi_st_t next_st;

  // ==========================================================================
  // address and data in either order; answer one cycle after both
  always_comb begin
    next_st = st;
    if (awvalid_i && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.waddr  = awaddr_i;
    end
    if (wvalid_i && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = wdata_i;
      next_st.wstrb = wstrb_i;
    end
    if (st.bvalid && bready_i) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = rif.wr_resp;
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready  = !next_st.w_got && !next_st.bvalid;
    // read path
    if (arvalid_i && st.arready) begin
      next_st.ar_got = 1'b1;
      next_st.raddr  = araddr_i;
    end
    if (st.rvalid && rready_i) begin
      next_st.rvalid = 1'b0;
    end
    if (st.ar_got) begin
      next_st.ar_got = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata  = rif.rd_data;
      next_st.rresp  = rif.rd_resp;
    end
    next_st.arready = !next_st.ar_got && !next_st.rvalid;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // register file strobes last one cycle
  assign rif.wr_stb  = st.aw_got && st.w_got;
  assign rif.wr_addr = st.waddr;
  assign rif.wr_data = st.wdata;
  assign rif.wr_strb = st.wstrb;
  assign rif.rd_stb  = st.ar_got;
  assign rif.rd_addr = st.raddr;
  assign awready_o   = st.awready;
  assign wready_o    = st.wready;
  assign bvalid_o    = st.bvalid;
  assign bresp_o     = st.bresp;
  assign arready_o   = st.arready;
  assign rvalid_o    = st.rvalid;
  assign rdata_o     = st.rdata;
  assign rresp_o     = st.rresp;
endmodule : dkrd_axil_slv
`default_nettype wire

// ---- dkrd_top.sv ----
// Our own choices: the AXI4-Lite register port and the address map.
`default_nettype none
module dkrd_top
  import dkrd_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input  wire logic        CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  output logic [15:0]      BUS_OUT_O,
  output logic             READ_FUNC_O,
  output logic             DATA_ACK_O,
  input  wire logic [15:0] PARCEL_I,
  input  wire logic        PARCEL_VALID_I,
  input  wire logic        DONE_I
);

  typedef struct packed {
    logic [3:0] opt;
    logic       typeb;
    logic [4:0] head;
    logic [5:0] sector;
    logic       cont;
    logic [5:0] next_sec;
  } dkrd_cmd_t;

  typedef struct packed {
    dkrd_state_t      state;
    logic [15:0]      bus_out;
    logic             func;
    logic             ack;
    logic             wbuf;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] len;
    dkrd_cmd_t        act;
    dkrd_cmd_t        pend;
    logic             pend_v;
    logic [15:0]      parc2;
    logic [15:0]      parc3;
    logic [15:0]      last_bo;
    logic [CNT_W:0]   raddr;
  } dkrd_top_st_t;

  dkrd_top_st_t st;
  dkrd_top_st_t next_st;
  dkrd_reg_if   rif ();
  dkrd_mem_if #(.AW(CNT_W + 1)) mif ();

  // ==========================================================================
  // helpers
  // read option legal for the selected drive type
  function automatic logic opt_ok(input logic [3:0] opt, input logic typeb);
    logic basic;
    basic = (opt <= DKRD_OPT_VEC);                              // [RULE_02]
    opt_ok = basic || (typeb && (opt == DKRD_OPT_HDR ||
             opt == DKRD_OPT_NOCONT || opt == DKRD_OPT_TBUF));  // [RULE_04]
  endfunction : opt_ok

  // bus-out word, unused bits low
  function automatic logic [15:0] form_bo(input dkrd_cmd_t c);
    if (c.typeb) begin
      form_bo = {c.opt, c.head, 1'b0, c.sector};                // [RULE_03]
    end else begin
      form_bo = {c.opt, 1'b0, c.head[2:0], 2'b00, c.sector};    // [RULE_01]
    end                                                         // [RULE_24]
  endfunction : form_bo

  // data reads move a long block, others a short one
  function automatic logic [CNT_W-1:0] xfer_len(input logic [3:0] opt);
    if (opt == DKRD_OPT_DATA || opt == DKRD_OPT_ABS ||
        opt == DKRD_OPT_NOCONT || opt == DKRD_OPT_TBUF) begin
      xfer_len = DKRD_LEN_LONG;
    end else begin
      xfer_len = DKRD_LEN_SHORT;                                // [RULE_10]
    end
  endfunction : xfer_len

  // track buffer slot to drive sector
  function automatic logic [5:0] slot_to_sector(input logic [5:0] slot);
    logic [5:0] drv;
    logic [5:0] rem;
    drv = slot / DKRD_SECT_PER_DRV;
    rem = slot % DKRD_SECT_PER_DRV;
    slot_to_sector = 6'((drv * DKRD_DRV_STRIDE) + rem);         // [RULE_09]
  endfunction : slot_to_sector

  // merge byte lanes 0 and 1 into a 16-bit register
  function automatic logic [15:0] lanes(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    lanes = old;
    if (s[0]) begin
      lanes[7:0] = d[7:0];
    end
    if (s[1]) begin
      lanes[15:8] = d[15:8];
    end
  endfunction : lanes

  // ==========================================================================
  // command from a cmd write and both parameter registers
  dkrd_cmd_t  new_cmd;
  logic [3:0] wr_opt;
  logic       wr_typeb;
  logic       slot_bad;

  assign wr_opt   = rif.wr_data[3:0];
  assign wr_typeb = rif.wr_data[DKRD_CMD_TYPEB_BIT];
  assign slot_bad = (wr_opt == DKRD_OPT_TBUF) &&
                    (st.parc3[5:0] >= DKRD_TRK_SECTORS);

  always_comb begin
    new_cmd        = '0;
    new_cmd.opt    = wr_opt;
    new_cmd.typeb  = wr_typeb;
    new_cmd.head   = wr_typeb ? st.parc2[11:7] : {2'b00, st.parc2[10:8]};
    new_cmd.sector = (wr_opt == DKRD_OPT_TBUF) ?
                     slot_to_sector(st.parc3[5:0]) : st.parc3[5:0];
    // continue applies to the basic data read only
    new_cmd.cont   = st.parc3[DKRD_CONT_BIT] &&
                     (wr_opt == DKRD_OPT_DATA);                 // [RULE_23]
    new_cmd.next_sec = st.parc2[5:0];                           // [RULE_23]
  end

  // ==========================================================================
  // register writes, transfer engine and queueing
  always_comb begin
    dkrd_cmd_t nxt;
    logic      take_cmd;
    logic      issue;
    nxt         = '0;
    take_cmd    = 1'b0;
    issue       = 1'b0;
    next_st     = st;
    next_st.func = 1'b0;
    next_st.ack  = 1'b0;
    rif.wr_resp = DKRD_RESP_OKAY;

    if (rif.wr_stb) begin
      unique case (rif.wr_addr)
        DKRD_CMD_OFF: begin
          // refused: queue full, bad code or track buffer slot past 47
          if (!opt_ok(wr_opt, wr_typeb) || slot_bad ||
              (st.state == DKRD_XFER && st.pend_v)) begin
            rif.wr_resp = DKRD_RESP_SLVERR;
          end else begin
            take_cmd = 1'b1;
          end
        end
        DKRD_PARC2_OFF: next_st.parc2 = lanes(st.parc2, rif.wr_data,
                                              rif.wr_strb);
        DKRD_PARC3_OFF: next_st.parc3 = lanes(st.parc3, rif.wr_data,
                                              rif.wr_strb);
        DKRD_BADDR_OFF: next_st.raddr = rif.wr_data[CNT_W:0];
        DKRD_STAT_OFF, DKRD_LASTBO_OFF, DKRD_BDATA_OFF: begin
          rif.wr_resp = DKRD_RESP_SLVERR;   // read-only
        end
        default: rif.wr_resp = DKRD_RESP_DECERR;
      endcase
    end

    unique case (st.state)
      DKRD_IDLE: begin
        if (take_cmd) begin
          issue = 1'b1;
          nxt   = new_cmd;
        end
      end
      DKRD_XFER: begin
        if (take_cmd) begin
          next_st.pend   = new_cmd;                             // [RULE_07]
          next_st.pend_v = 1'b1;
        end
        // parcels past the length are dropped
        if (PARCEL_VALID_I && st.cnt < st.len) begin
          next_st.cnt = st.cnt + 1'b1;
          if (st.cnt[3:0] == 4'hf) begin
            next_st.ack     = 1'b1;                             // [RULE_22]
            next_st.bus_out = {DKRD_FN_DATA_ACK, 12'h000};      // [RULE_24]
          end
        end
        if (DONE_I) begin
          next_st.wbuf = !st.wbuf;                              // [RULE_22]
          if (st.pend_v) begin
            issue          = 1'b1;                              // [RULE_07]
            nxt            = st.pend;
            next_st.pend_v = take_cmd;
          end else if (take_cmd) begin
            issue = 1'b1;
            nxt   = new_cmd;
          end else if (st.act.cont) begin
            issue      = 1'b1;                                  // [RULE_07]
            nxt        = st.act;
            nxt.sector = st.act.next_sec;                       // [RULE_23]
          end else begin
            next_st.state = DKRD_IDLE;
          end
        end
      end
    endcase

    // a new read overrides an ack word in the same cycle
    if (issue) begin
      next_st.state   = DKRD_XFER;
      next_st.act     = nxt;
      next_st.bus_out = form_bo(nxt);
      next_st.last_bo = form_bo(nxt);
      next_st.func    = 1'b1;
      next_st.ack     = 1'b0;
      next_st.cnt     = '0;
      next_st.len     = xfer_len(nxt.opt);
    end
  end

  // ==========================================================================
  // reads come from state; buffer data from the ram flop
  always_comb begin
    rif.rd_data = 32'h0000_0000;
    rif.rd_resp = DKRD_RESP_OKAY;
    unique case (rif.rd_addr)
      DKRD_CMD_OFF: begin
        rif.rd_data[3:0]               = st.act.opt;
        rif.rd_data[DKRD_CMD_TYPEB_BIT] = st.act.typeb;
      end
      DKRD_PARC2_OFF:  rif.rd_data[15:0] = st.parc2;
      DKRD_PARC3_OFF:  rif.rd_data[15:0] = st.parc3;
      DKRD_STAT_OFF: begin
        rif.rd_data[0] = (st.state == DKRD_XFER);
        rif.rd_data[1] = st.pend_v;
        rif.rd_data[2] = st.wbuf;
        rif.rd_data[3] = st.act.cont;
        rif.rd_data[16 +: CNT_W] = st.cnt;
      end
      DKRD_LASTBO_OFF: rif.rd_data[15:0] = st.last_bo;
      DKRD_BADDR_OFF:  rif.rd_data[CNT_W:0] = st.raddr;
      DKRD_BDATA_OFF:  rif.rd_data[15:0] = mif.rdata;
      default:         rif.rd_resp = DKRD_RESP_DECERR;
    endcase
  end

  // ==========================================================================
  // parcels land in the current write buffer
  assign mif.we    = (st.state == DKRD_XFER) && PARCEL_VALID_I &&
                     (st.cnt < st.len);                         // [RULE_22]
  assign mif.waddr = {st.wbuf, st.cnt};
  assign mif.wdata = PARCEL_I;
  assign mif.raddr = st.raddr;

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st       <= '0;
      st.parc2 <= DKRD_REG_RST;
      st.parc3 <= DKRD_REG_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs and children
  assign BUS_OUT_O   = st.bus_out;
  assign READ_FUNC_O = st.func;
  assign DATA_ACK_O  = st.ack;

  dkrd_buf_mem #(.AW(CNT_W + 1)) u_mem (
    .clk_i (CLK_I),
    .port  (mif)
  );

  dkrd_axil_slv u_slv (
    .clk_i     (CLK_I),
    .resetn_i  (RESETN_I),
    .awaddr_i  (S_AXI_AWADDR_I),
    .awvalid_i (S_AXI_AWVALID_I),
    .awready_o (S_AXI_AWREADY_O),
    .wdata_i   (S_AXI_WDATA_I),
    .wstrb_i   (S_AXI_WSTRB_I),
    .wvalid_i  (S_AXI_WVALID_I),
    .wready_o  (S_AXI_WREADY_O),
    .bresp_o   (S_AXI_BRESP_O),
    .bvalid_o  (S_AXI_BVALID_O),
    .bready_i  (S_AXI_BREADY_I),
    .araddr_i  (S_AXI_ARADDR_I),
    .arvalid_i (S_AXI_ARVALID_I),
    .arready_o (S_AXI_ARREADY_O),
    .rdata_o   (S_AXI_RDATA_O),
    .rresp_o   (S_AXI_RRESP_O),
    .rvalid_o  (S_AXI_RVALID_O),
    .rready_i  (S_AXI_RREADY_I),
    .rif       (rif)
  );
endmodule : dkrd_top
`default_nettype wire

// ---- dkrd_chk_assertions.sv ----
`default_nettype none
// ==========================================
// bus-out and ack timing at the top ports
module dkrd_chk
  import dkrd_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        RESETN_I,
  input wire logic        S_AXI_BVALID_O,
  input wire logic [15:0] BUS_OUT_O,
  input wire logic        READ_FUNC_O,
  input wire logic        DATA_ACK_O,
  input wire logic        PARCEL_VALID_I,
  input wire logic        DONE_I
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pcnt;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  // parcels since issue, modulo one ack block
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) pcnt <= 4'h0;
    else if (READ_FUNC_O) pcnt <= 4'h0;
    else if (PARCEL_VALID_I) pcnt <= pcnt + 4'h1;
  end
  sequence s_blk_end; PARCEL_VALID_I && pcnt == 4'hf; endsequence
  property p_ack_due; s_blk_end |-> ##[1:2] DATA_ACK_O; endproperty
  a_ack_due: assert property (p_ack_due) else $error("ack late");
  property p_ack_one; DATA_ACK_O |=> !DATA_ACK_O; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack long");
  property p_ack_why; DATA_ACK_O |-> pcnt == 4'h0 && !READ_FUNC_O; endproperty
  a_ack_why: assert property (p_ack_why) else $error("stray ack");
  property p_ack_word;
    DATA_ACK_O |-> BUS_OUT_O == {DKRD_FN_DATA_ACK, 12'h000};
  endproperty
  a_ack_word: assert property (p_ack_word) else $error("ack word");
  property p_opt_ok;
    READ_FUNC_O |-> BUS_OUT_O[15:12] inside {[4'h0:4'h6], 4'h8, 4'ha};
  endproperty
  a_opt_ok: assert property (p_opt_ok) else $error("bad option");
  property p_bit6; READ_FUNC_O |-> !BUS_OUT_O[6]; endproperty
  a_bit6: assert property (p_bit6) else $error("bit 6 set");
  property p_slot;
    READ_FUNC_O && BUS_OUT_O[15:12] == 4'ha |-> BUS_OUT_O[3:0] < 4'hc;
  endproperty
  a_slot: assert property (p_slot) else $error("bad drive sector");
  property p_cause;
    READ_FUNC_O |-> $rose(S_AXI_BVALID_O) || $past(DONE_I);
  endproperty
  a_cause: assert property (p_cause) else $error("issue uncaused");
endmodule : dkrd_chk
bind dkrd_top dkrd_chk u_chk (.*);
`default_nettype wire

// ---- dkrd_drive_model.sv ----
`default_nettype none
// ==========================================
// drive: one read at a time, waits for acks
module dkrd_drive_model #(
  parameter int GAP = 2
) (
  input  wire logic        clk_i,
  input  wire logic [15:0] bus_out_i,
  input  wire logic        read_func_i,
  input  wire logic        data_ack_i,
  output logic      [15:0] parcel_o,
  output logic             parcel_valid_o,
  output logic             done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int n, len, k;
  // gap stands for the sector search
  // payload is a count
  initial begin
    parcel_o = 16'hffff;
    parcel_valid_o = 1'b0;
    done_o = 1'b0;
    forever begin
      @(negedge clk_i);
      if (read_func_i === 1'b1) begin
        len = 16;
        if (bus_out_i[15:12] inside {4'h0, 4'h2, 4'h8, 4'ha}) len = 2048;
        repeat (GAP) @(posedge clk_i);
        for (n = 0; n < len; n++) begin
          @(posedge clk_i);
          parcel_o <= 16'h5a00 + 16'(n);
          parcel_valid_o <= 1'b1;
          if (n % 16 == 15) begin
            @(posedge clk_i);
            parcel_o <= ~parcel_o; // released line must not look held
            parcel_valid_o <= 1'b0;
            for (k = 0; k < 8 && data_ack_i !== 1'b1; k++) @(negedge clk_i);
            repeat (GAP) @(posedge clk_i);
          end
        end
        @(posedge clk_i);
        done_o <= 1'b1;
        @(posedge clk_i);
        done_o <= 1'b0;
      end
    end
  end
endmodule : dkrd_drive_model
`default_nettype wire

// ---- test_disk_read_command_formatter.sv ----
`default_nettype none
module test_disk_read_command_formatter;
  import dkrd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
  logic        arv = 1'b0, rrdy = 1'b0, awr, wr_o, bv, arr, rv, wb = 1'b0;
  logic        rf, ack, pv, dn;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, d;
  logic [1:0]  br, rr, r;
  logic [15:0] bo, pc, rfw;
  logic [3:0]  opb [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
  int          errors = 0, checks = 0, rfc = 0, i, n;
  // ==========================================
  // clock, design and drive
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  dkrd_top DUT (.CLK_I(clk), .RESETN_I(rstn), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_o),
    .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(brdy),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rrdy), .BUS_OUT_O(bo), .READ_FUNC_O(rf),
    .DATA_ACK_O(ack), .PARCEL_I(pc), .PARCEL_VALID_I(pv), .DONE_I(dn));
  dkrd_drive_model u_drv (.clk_i(clk), .bus_out_i(bo), .read_func_i(rf),
    .data_ack_i(ack), .parcel_o(pc), .parcel_valid_o(pv), .done_o(dn));
  // issued words and buffer flips
  always @(negedge clk) begin
    if (rf === 1'b1) begin
      rfw = bo;
      rfc++;
    end
    if (dn === 1'b1) wb = ~wb;
  end
  // ==========================================
  // reporting
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      errors++;
      $display("ERROR %0t wait ran out", $time);
      summarize();
    end
  endtask : tmo
  // ==========================================
  // bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    logic ah, wh, bh;
    int k;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    bh = 1'b0;
    for (k = 0; k < 64 && !bh; k++) begin
      @(negedge clk);
      ah = awv && awr;
      wh = wv && wr_o;
      bh = bv;
      r = br;
      @(posedge clk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end
    brdy <= 1'b0;
    tmo(bh);
    chk(r, er);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    logic ah, rh;
    int k;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    rh = 1'b0;
    for (k = 0; k < 64 && !rh; k++) begin
      @(negedge clk);
      ah = arv && arr;
      rh = rv;
      d = rd;
      r = rr;
      @(posedge clk);
      if (ah) arv <= 1'b0;
    end
    rrdy <= 1'b0;
    tmo(rh);
  endtask : rdr
  task automatic wait_rf(input int m);
    int k;
    for (k = 0; k < 9000 && rfc < m; k++) @(posedge clk);
    tmo(rfc >= m);
  endtask : wait_rf
  task automatic wait_idle();
    int k;
    d = 32'h1;
    for (k = 0; k < 3000 && d[0] !== 1'b0; k++) rdr(DKRD_STAT_OFF);
    tmo(d[0] === 1'b0);
  endtask : wait_idle
  // one read, checked three ways
  task automatic op(input logic b, input logic [3:0] o, input logic [5:0] s);
    logic [15:0] e;
    e = b ? {o, 5'h13, 1'b0, s} : {o, 4'h5, 2'b00, s};
    n = rfc + 1;
    wr(DKRD_CMD_OFF, {23'h0, b, 4'h0, o}, DKRD_RESP_OKAY);
    wait_rf(n);
    chk(rfw, e);
    wait_idle();
    chk(d[2], wb);
    rdr(DKRD_LASTBO_OFF);
    chk(d, {16'h0, e});
  endtask : op
  // ==========================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 3; i++) begin
      rdr(8'(4 * i));
      chk(d, {16'h0, DKRD_REG_RST});
    end
    // stray parcel bits 11 and 6 must stay off bus-out
    wr(DKRD_PARC2_OFF, 32'h0d7f, DKRD_RESP_OKAY);
    wr(DKRD_PARC3_OFF, 32'h006a, DKRD_RESP_OKAY);
    for (i = 0; i < 6; i++) op(1'b0, 4'(i), 6'h2a);
    wr(DKRD_PARC2_OFF, 32'h09ff, DKRD_RESP_OKAY);
    for (i = 0; i < 8; i++) op(1'b1, opb[i], 6'h2a);
    op(1'b1, 4'ha, 6'h36);
    wr(DKRD_BADDR_OFF, {19'h0, ~wb, 12'h003}, DKRD_RESP_OKAY);
    rdr(DKRD_BDATA_OFF);
    chk(d, 32'h5a03);
    // refusals leave bus-out alone
    n = rfc;
    wr(DKRD_CMD_OFF, 32'h6, DKRD_RESP_SLVERR);
    wr(DKRD_PARC3_OFF, 32'h30, DKRD_RESP_OKAY);
    wr(DKRD_CMD_OFF, 32'h10a, DKRD_RESP_SLVERR);
    wr(DKRD_STAT_OFF, 32'h0, DKRD_RESP_SLVERR);
    wr(8'h1c, 32'h0, DKRD_RESP_DECERR);
    rdr(8'h20);
    chk({r, d[29:0]}, {DKRD_RESP_DECERR, 30'h0});
    chk(rfc, n);
    // continue, then a queued read wins
    wr(DKRD_PARC2_OFF, 32'h0511, DKRD_RESP_OKAY);
    wr(DKRD_PARC3_OFF, 32'h8005, DKRD_RESP_OKAY);
    wr(DKRD_CMD_OFF, 32'h0, DKRD_RESP_OKAY);
    wait_rf(n + 1);
    chk(rfw, 16'h0505);
    wait_rf(n + 2);
    chk(rfw, 16'h0511);
    wr(DKRD_CMD_OFF, 32'h3, DKRD_RESP_OKAY);
    wr(DKRD_CMD_OFF, 32'h3, DKRD_RESP_SLVERR);
    wait_rf(n + 3);
    chk(rfw, 16'h3505);
    wait_idle();
    chk(rfc, n + 3);
    summarize();
  end
endmodule : test_disk_read_command_formatter
`default_nettype wire
